// *** rtl/sct_ctl.sv ***
`timescale 1ns/1ps
// What this block does
// - Background run reports completion once command data is taken in.
// - Blocking run reports completion only after the whole write ends.
// - Any command but status query ends a background run, then executes.
// - Status error code reads all ones while the write runs.
// - Clean finish sets status error code to zero.
// - Early end leaves a code between zero and all ones.
// - Host command abort of background run gives code 0008h.
// - Unrecoverable error ending background run gives code 0009h.
// - Error outcome: status 51h, code in count/number, error register abort.
// - Unrecoverable error ending blocking write gives code 0017h.
// - Action 0003h sets or returns read or write recovery timer.
// - Set value is in 100 ms units, minimum 65.
// - Set below six and a half seconds is aborted.
// - Return gives limit in count/number, error 00h, status 50h.
// - Non-queued commands are timed up to completion report.
// - Queued in-order commands are timed from execution start.
// - Streaming and out-of-order queued commands are not timed.
// - Timers are volatile, default zero, zero disables time-out.
module sct_ctl
#(
   parameter int UNIT_CYC = sct_pkg::RT_UNIT_CYC
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic key_valid_i,
   input wire sct_pkg::sct_key_s key_i,
   input wire logic data_done_i,
   input wire logic seg_done_i,
   input wire logic seg_fail_i,
   input wire logic host_cmd_i,
   input wire logic host_cmd_status_i,
   input wire logic cmd_start_i,
   input wire logic cmd_complete_i,
   input wire logic cmd_is_read_i,
   input wire logic cmd_queued_i,
   input wire logic cmd_stream_i,
   input wire logic ooo_enable_i,
   output logic done_o,
   output sct_pkg::sct_tf_s tf_o,
   output logic [15:0] ext_status_o,
   output logic seg_active_o,
   output logic seg_stop_o,
   output logic host_cmd_go_o,
   output logic timeout_o
);
   import sct_pkg::*;

   // ==========================================================
   // Command sequencer
   sct_state_e state, next_state;
   logic [15:0] next_ext;
   logic next_done, next_active, next_stop, next_go;
   sct_tf_s next_tf;
   logic mem_wr, mem_wsel, mem_rsel;
   logic [15:0] mem_rdata, rd_lim, wr_lim;
   logic get_pend, next_get_pend;

   function automatic sct_tf_s err_tf(input logic [15:0] code);
      err_tf = '{err: ER_ABORT, cnt: code[7:0], num: code[15:8], stat: ST_ERR};
   endfunction

   always_comb
   begin
      next_state = state;
      next_ext = ext_status_o;
      next_done = 1'b0;
      next_active = seg_active_o;
      next_stop = 1'b0;
      next_go = 1'b0;
      next_tf = tf_o;
      mem_wr = 1'b0;
      mem_wsel = (key_i.sel == SEL_WRITE);
      mem_rsel = mem_wsel;
      next_get_pend = 1'b0;
      unique case (state)
         SCT_IDLE:
         begin
            if (get_pend)
            begin
               next_tf = '{err: ER_NONE, cnt: mem_rdata[7:0],
                  num: mem_rdata[15:8], stat: ST_OK};
               next_done = 1'b1;
            end
            else if (key_valid_i && key_i.action == ACT_SEGMENT)
            begin
               if (key_i.func == FN_BG_PATTERN || key_i.func == FN_BG_SECTOR)
               begin
                  next_state = SCT_BG;
                  next_ext = ES_RUNNING;
                  next_active = 1'b1;
               end
               else if (key_i.func == FN_BLK_PATTERN || key_i.func == FN_BLK_SECTOR)
               begin
                  next_state = SCT_BLK;
                  next_ext = ES_RUNNING;
                  next_active = 1'b1;
               end
               else
               begin
                  next_tf = err_tf(ext_status_o);
                  next_done = 1'b1;
               end
            end
            else if (key_valid_i && key_i.action == ACT_RECOVERY)
            begin
               if (key_i.func == FN_SET && key_i.value >= RT_MIN)
               begin
                  mem_wr = 1'b1;
                  next_tf = '{err: ER_NONE, cnt: 8'h00, num: 8'h00, stat: ST_OK};
                  next_done = 1'b1;
               end
               else if (key_i.func == FN_GET)
               begin
                  next_get_pend = 1'b1;
               end
               else
               begin
                  next_tf = err_tf(ext_status_o);
                  next_done = 1'b1;
               end
            end
            else if (host_cmd_i)
            begin
               next_go = 1'b1;
            end
         end
         SCT_BG:
         begin
            if (data_done_i)
            begin
               next_tf = '{err: ER_NONE, cnt: 8'h01, num: 8'h00, stat: ST_OK};
               next_done = 1'b1;
            end
            if (host_cmd_i && !host_cmd_status_i)
            begin
               next_ext = ES_BG_ABORT;
               next_stop = 1'b1;
               next_go = 1'b1;
               next_active = 1'b0;
               next_state = SCT_IDLE;
            end
            else if (seg_fail_i)
            begin
               next_ext = ES_BG_FAIL;
               next_active = 1'b0;
               next_state = SCT_IDLE;
            end
            else if (seg_done_i)
            begin
               next_ext = ES_DONE;
               next_active = 1'b0;
               next_state = SCT_IDLE;
            end
            else if (host_cmd_i)
            begin
               next_go = 1'b1;
            end
         end
         SCT_BLK:
         begin
            if (seg_fail_i)
            begin
               next_ext = ES_BLK_FAIL;
               next_tf = err_tf(ES_BLK_FAIL);
               next_active = 1'b0;
               next_state = SCT_RESP;
            end
            else if (seg_done_i)
            begin
               next_ext = ES_DONE;
               next_tf = '{err: ER_NONE, cnt: 8'h01, num: 8'h00, stat: ST_OK};
               next_active = 1'b0;
               next_state = SCT_RESP;
            end
         end
         SCT_RESP:
         begin
            next_done = 1'b1;
            next_state = SCT_IDLE;
         end
         default:
         begin
            next_state = SCT_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state <= SCT_IDLE;
         ext_status_o <= ES_DONE;
         done_o <= 1'b0;
         seg_active_o <= 1'b0;
         seg_stop_o <= 1'b0;
         host_cmd_go_o <= 1'b0;
         tf_o <= '{err: ER_NONE, cnt: 8'h00, num: 8'h00, stat: ST_OK};
         get_pend <= 1'b0;
      end
      else
      begin
         state <= next_state;
         ext_status_o <= next_ext;
         done_o <= next_done;
         seg_active_o <= next_active;
         seg_stop_o <= next_stop;
         host_cmd_go_o <= next_go;
         tf_o <= next_tf;
         get_pend <= next_get_pend;
      end
   end

   sct_tmr_mem u_mem
   (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .wr_i(mem_wr),
      .wsel_i(mem_wsel),
      .wdata_i(key_i.value),
      .rsel_i(mem_rsel),
      .rdata_o(mem_rdata),
      .rd_lim_o(rd_lim),
      .wr_lim_o(wr_lim)
   );

   // ==========================================================
   // Recovery time-out counter
   // Zero limit keeps the counter idle, so no time-out can fire
   logic timing, next_timing;
   logic [31:0] sub_cnt, next_sub_cnt;
   logic [15:0] unit_cnt, next_unit_cnt;
   logic [15:0] limit;
   logic next_timeout;
   logic timed_cmd;

   always_comb
   begin
      limit = cmd_is_read_i ? rd_lim : wr_lim;
      timed_cmd = !cmd_stream_i && !(cmd_queued_i && ooo_enable_i);
      next_timing = timing;
      next_sub_cnt = sub_cnt;
      next_unit_cnt = unit_cnt;
      next_timeout = 1'b0;
      if (cmd_complete_i)
      begin
         next_timing = 1'b0;
      end
      else if (cmd_start_i)
      begin
         next_timing = timed_cmd && (limit != 16'h0000);
         next_sub_cnt = 32'h0;
         next_unit_cnt = 16'h0;
      end
      else if (timing)
      begin
         if (sub_cnt == 32'(UNIT_CYC - 1))
         begin
            next_sub_cnt = 32'h0;
            next_unit_cnt = unit_cnt + 16'h1;
            if (unit_cnt + 16'h1 >= limit)
            begin
               next_timeout = 1'b1;
               next_timing = 1'b0;
            end
         end
         else
         begin
            next_sub_cnt = sub_cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         timing <= 1'b0;
         sub_cnt <= 32'h0;
         unit_cnt <= 16'h0;
         timeout_o <= 1'b0;
      end
      else
      begin
         timing <= next_timing;
         sub_cnt <= next_sub_cnt;
         unit_cnt <= next_unit_cnt;
         timeout_o <= next_timeout;
      end
   end

   // ==========================================================
   // Checks
   property p_run_code;
      @(posedge ref_clk_i) disable iff (rst_i)
      (state == SCT_BG || state == SCT_BLK) |-> ext_status_o == ES_RUNNING;
   endproperty
   a_run_code: assert property (p_run_code) else $error("run code not FFFF");

   property p_bg_abort;
      @(posedge ref_clk_i) disable iff (rst_i)
      (state == SCT_BG && host_cmd_i && !host_cmd_status_i)
      |=> ext_status_o == ES_BG_ABORT && seg_stop_o && host_cmd_go_o;
   endproperty
   a_bg_abort: assert property (p_bg_abort) else $error("abort not reported");

   property p_bg_fail;
      @(posedge ref_clk_i) disable iff (rst_i)
      (state == SCT_BG && !host_cmd_i && seg_fail_i) |=> ext_status_o == ES_BG_FAIL;
   endproperty
   a_bg_fail: assert property (p_bg_fail) else $error("bg fail code wrong");

   property p_blk_fail;
      @(posedge ref_clk_i) disable iff (rst_i)
      (state == SCT_BLK && seg_fail_i)
      |=> ##1 done_o && tf_o.stat == ST_ERR && tf_o.err == ER_ABORT && tf_o.cnt == 8'h17;
   endproperty
   a_blk_fail: assert property (p_blk_fail) else $error("blocking error image wrong");

   property p_blk_hold;
      @(posedge ref_clk_i) disable iff (rst_i)
      (state == SCT_BLK) |-> !done_o;
   endproperty
   a_blk_hold: assert property (p_blk_hold) else $error("early blocking completion");

   property p_bg_done;
      @(posedge ref_clk_i) disable iff (rst_i)
      (state == SCT_BG && data_done_i) |=> done_o && tf_o.stat == ST_OK;
   endproperty
   a_bg_done: assert property (p_bg_done) else $error("bg completion missing");

   property p_set_min;
      @(posedge ref_clk_i) disable iff (rst_i)
      (state == SCT_IDLE && !get_pend && key_valid_i && key_i.action == ACT_RECOVERY
         && key_i.func == FN_SET && key_i.value < RT_MIN)
      |=> done_o && tf_o.stat == ST_ERR && $stable(rd_lim) && $stable(wr_lim);
   endproperty
   a_set_min: assert property (p_set_min) else $error("short limit accepted");

   property p_zero_off;
      @(posedge ref_clk_i) disable iff (rst_i)
      (limit == 16'h0000 && cmd_start_i && !cmd_complete_i) |=> !timing;
   endproperty
   a_zero_off: assert property (p_zero_off) else $error("zero limit timed");

   property p_no_stream;
      @(posedge ref_clk_i) disable iff (rst_i)
      (cmd_start_i && !cmd_complete_i && cmd_stream_i) |=> !timing;
   endproperty
   a_no_stream: assert property (p_no_stream) else $error("stream cmd timed");
endmodule // sct_ctl

// *** include/sct_pkg.sv ***
package sct_pkg;
   // ==========================================================
   // Key sector codes
   localparam logic [15:0] ACT_SEGMENT = 16'h0002;
   localparam logic [15:0] ACT_RECOVERY = 16'h0003;
   localparam logic [15:0] FN_BG_PATTERN = 16'h0001;
   localparam logic [15:0] FN_BG_SECTOR = 16'h0002;
   localparam logic [15:0] FN_BLK_PATTERN = 16'h0101;
   localparam logic [15:0] FN_BLK_SECTOR = 16'h0102;
   localparam logic [15:0] FN_SET = 16'h0001;
   localparam logic [15:0] FN_GET = 16'h0002;
   localparam logic [15:0] SEL_READ = 16'h0001;
   localparam logic [15:0] SEL_WRITE = 16'h0002;
   // ==========================================================
   // Status codes
   localparam logic [15:0] ES_RUNNING = 16'hFFFF;
   localparam logic [15:0] ES_DONE = 16'h0000;
   localparam logic [15:0] ES_BG_ABORT = 16'h0008;
   localparam logic [15:0] ES_BG_FAIL = 16'h0009;
   localparam logic [15:0] ES_BLK_FAIL = 16'h0017;
   localparam logic [7:0] ST_OK = 8'h50;
   localparam logic [7:0] ST_ERR = 8'h51;
   localparam logic [7:0] ER_NONE = 8'h00;
   localparam logic [7:0] ER_ABORT = 8'h04;
   // ==========================================================
   // Recovery timer
   localparam logic [15:0] RT_MIN = 16'd65;
   localparam int RT_UNIT_MS = 100;
   localparam int CLK_MHZ = 100;
   localparam int RT_UNIT_CYC = RT_UNIT_MS * 1000 * CLK_MHZ;
   localparam logic [15:0] RT_RESET = 16'h0000;

   typedef struct packed
   {
      logic [15:0] action;
      logic [15:0] func;
      logic [15:0] sel;
      logic [15:0] value;
   } sct_key_s;

   typedef struct packed
   {
      logic [7:0] err;
      logic [7:0] cnt;
      logic [7:0] num;
      logic [7:0] stat;
   } sct_tf_s;

   typedef enum logic [3:0]
   {
      SCT_IDLE = 4'b0001,
      SCT_BG = 4'b0010,
      SCT_BLK = 4'b0100,
      SCT_RESP = 4'b1000
   } sct_state_e;
endpackage

// *** rtl/sct_tmr_mem.sv ***
`timescale 1ns/1ps
// ==========================================================
// Two-word timer limit store, volatile, registered read
module sct_tmr_mem
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic wsel_i,
   input wire logic [15:0] wdata_i,
   input wire logic rsel_i,
   output logic [15:0] rdata_o,
   output logic [15:0] rd_lim_o,
   output logic [15:0] wr_lim_o
);
   import sct_pkg::*;
   logic [15:0] mem [2];
   logic [15:0] next_mem [2];
   logic [15:0] next_rdata;

   always_comb
   begin
      next_mem = mem;
      if (wr_i)
      begin
         next_mem[wsel_i] = wdata_i;
      end
      next_rdata = next_mem[rsel_i];
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mem[0] <= RT_RESET;
         mem[1] <= RT_RESET;
         rdata_o <= RT_RESET;
      end
      else
      begin
         mem <= next_mem;
         rdata_o <= next_rdata;
      end
   end

   assign rd_lim_o = mem[0];
   assign wr_lim_o = mem[1];
endmodule // sct_tmr_mem

// *** dv/sct_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Host side: issues key sectors and task-file commands
module sct_host_model
(
   input wire logic ref_clk_i,
   output logic key_valid_o,
   output sct_pkg::sct_key_s key_o,
   output logic host_cmd_o,
   output logic host_cmd_status_o
);
   import sct_pkg::*;

   initial
   begin
      key_valid_o = 1'b0;
      key_o = '0;
      host_cmd_o = 1'b0;
      host_cmd_status_o = 1'b0;
   end

   // Callers hand over any action and function codes, undefined ones such as 0003h and 0005h included
   task automatic send_key(input sct_key_s k);
      @(posedge ref_clk_i);
      key_valid_o <= 1'b1;
      key_o <= k;
      @(posedge ref_clk_i);
      key_valid_o <= 1'b0;
      // Released fields scrambled so a stale key never looks fresh
      key_o <= ~k;
   endtask

   task automatic issue(input logic status);
      @(posedge ref_clk_i);
      host_cmd_o <= 1'b1;
      host_cmd_status_o <= status;
      @(posedge ref_clk_i);
      host_cmd_o <= 1'b0;
      host_cmd_status_o <= ~status;
   endtask
endmodule // sct_host_model

// *** dv/tb.sv ***
`timescale 1ns/1ps
// ==========================================================
// Top bench
module tb;
   import sct_pkg::*;
   // Short unit keeps timer runs to a few hundred cycles
   localparam int UNIT = 4;
   logic ref_clk_i;
   logic rst_i;
   logic [4:0] pul;
   logic [3:0] lv;
   logic key_valid;
   sct_key_s key;
   logic host_cmd;
   logic host_status;
   logic done_o;
   sct_tf_s tf_o;
   logic [15:0] ext_status_o;
   logic seg_active_o;
   logic seg_stop_o;
   logic host_cmd_go_o;
   logic timeout_o;
   logic [3:0] obs;
   logic [15:0] sel;
   logic [15:0] lim [2];
   int fail_count;
   int checked;
   int n;

   assign obs = {seg_stop_o, host_cmd_go_o, timeout_o, done_o};

   sct_host_model u_host
   (
      .ref_clk_i(ref_clk_i),
      .key_valid_o(key_valid),
      .key_o(key),
      .host_cmd_o(host_cmd),
      .host_cmd_status_o(host_status)
   );

   sct_ctl #(.UNIT_CYC(UNIT)) u_dut
   (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .key_valid_i(key_valid),
      .key_i(key),
      .data_done_i(pul[0]),
      .seg_done_i(pul[1]),
      .seg_fail_i(pul[2]),
      .host_cmd_i(host_cmd),
      .host_cmd_status_i(host_status),
      .cmd_start_i(pul[3]),
      .cmd_complete_i(pul[4]),
      .cmd_is_read_i(lv[3]),
      .cmd_queued_i(lv[2]),
      .cmd_stream_i(lv[1]),
      .ooo_enable_i(lv[0]),
      .done_o(done_o),
      .tf_o(tf_o),
      .ext_status_o(ext_status_o),
      .seg_active_o(seg_active_o),
      .seg_stop_o(seg_stop_o),
      .host_cmd_go_o(host_cmd_go_o),
      .timeout_o(timeout_o)
   );

   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   // ==========================================================
   // Helpers
   function automatic sct_key_s mk(input logic [15:0] a, f, s, v);
      return {a, f, s, v};
   endfunction

   function automatic logic [15:0] bg_end(input int i);
      return (i == 0) ? ES_DONE : (i == 1) ? ES_BG_ABORT : ES_BG_FAIL;
   endfunction

   function automatic logic [31:0] img(input logic [15:0] code, input logic bad);
      return {bad ? ER_ABORT : ER_NONE, code[7:0], code[15:8], bad ? ST_ERR : ST_OK};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   // Called on an edge; counts edges up to the one that samples the flag high
   // A pulse launched on the calling edge itself is caught by the first look
   task automatic waitfor(input int s, input int lim_n, output int k);
      k = 0;
      #1;
      while (obs[s] !== 1'b1 && k < lim_n)
      begin
         @(posedge ref_clk_i);
         #1;
         k++;
      end
      k++;
   endtask

   task automatic key_done(input sct_key_s k, input int lat);
      int m;
      u_host.send_key(k);
      waitfor(0, 6, m);
      chk(m, lat);
   endtask

   task automatic pulse(input int i);
      @(posedge ref_clk_i);
      pul[i] <= 1'b1;
      @(posedge ref_clk_i);
      pul[i] <= 1'b0;
   endtask

   // Completion is raised stop+2 cycles after start is raised; -1 never completes
   task automatic tmr(input logic [3:0] l, input int stop, output int k);
      @(posedge ref_clk_i);
      lv <= l;
      pul[3] <= 1'b1;
      @(posedge ref_clk_i);
      pul[3] <= 1'b0;
      k = 0;
      while (k < 400 && timeout_o !== 1'b1)
      begin
         @(posedge ref_clk_i);
         pul[4] <= (k == stop);
         #1;
         k++;
      end
   endtask

   task automatic chkn(input int k, input int e);
      chk(k >= e - 1 && k <= e + 2, 1'b1);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      fail_count++;
      conclude();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      fail_count = 0;
      checked = 0;
      pul = '0;
      lv = '0;
      sel = SEL_READ;
      rst_i = 1'b1;
      void'($urandom(32'h2a11));
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      for (int s = 0; s < 2; s++)
      begin
         sel = s ? SEL_WRITE : SEL_READ;
         key_done(mk(ACT_RECOVERY, FN_GET, sel, 16'h0000), 2);
         chk(tf_o, img(RT_RESET, 1'b0));
      end
      tmr(4'b0000, -1, n);
      chk(timeout_o, 1'b0);
      for (int s = 0; s < 2; s++)
      begin
         sel = s ? SEL_WRITE : SEL_READ;
         lim[s] = 16'($urandom_range(64, 0));
         key_done(mk(ACT_RECOVERY, FN_SET, sel, lim[s]), 1);
         chk({tf_o.err, tf_o.stat}, {ER_ABORT, ST_ERR});
         key_done(mk(ACT_RECOVERY, FN_GET, sel, 16'h0000), 2);
         chk(tf_o, img(RT_RESET, 1'b0));
         lim[s] = s ? 16'($urandom_range(80, 66)) : RT_MIN;
         key_done(mk(ACT_RECOVERY, FN_SET, sel, lim[s]), 1);
         chk({tf_o.err, tf_o.stat}, {ER_NONE, ST_OK});
         key_done(mk(ACT_RECOVERY, FN_GET, sel, 16'h0000), 2);
         chk(tf_o, img(lim[s], 1'b0));
      end
      key_done(mk(ACT_RECOVERY, 16'h0005, SEL_READ, RT_MIN), 1);
      chk({tf_o.err, tf_o.stat}, {ER_ABORT, ST_ERR});
      tmr(4'b1000, -1, n);
      chkn(n, lim[0] * UNIT);
      tmr(4'b0100, -1, n);
      chkn(n, lim[1] * UNIT);
      tmr(4'b1010, -1, n);
      chk(timeout_o, 1'b0);
      tmr(4'b1101, -1, n);
      chk(timeout_o, 1'b0);
      tmr(4'b1000, 20, n);
      chk(timeout_o, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         u_host.send_key(mk(ACT_SEGMENT, i[0] ? FN_BG_SECTOR : FN_BG_PATTERN, 16'h0, 16'h0));
         @(posedge ref_clk_i);
         #1;
         chk({seg_active_o, ext_status_o}, {1'b1, ES_RUNNING});
         pulse(0);
         waitfor(0, 6, n);
         chk(n, 1);
         chk(tf_o, img(16'h0001, 1'b0));
         u_host.issue(1'b1);
         waitfor(2, 6, n);
         chk({seg_active_o, ext_status_o}, {1'b1, ES_RUNNING});
         if (i == 1)
         begin
            u_host.issue(1'b0);
            waitfor(3, 6, n);
            chk({n[3:0], host_cmd_go_o}, {4'h1, 1'b1});
         end
         else
            pulse(i == 0 ? 1 : 2);
         repeat (2) @(posedge ref_clk_i);
         #1;
         chk({seg_active_o, ext_status_o}, {1'b0, bg_end(i)});
         if (i > 0)
            chk(ext_status_o !== ES_DONE && ext_status_o !== ES_RUNNING, 1'b1);
         u_host.issue(1'b1);
         waitfor(2, 6, n);
         chk(ext_status_o, bg_end(i));
      end
      key_done(mk(ACT_SEGMENT, 16'h0003, 16'h0, 16'h0), 1);
      chk(tf_o, img(ES_BG_FAIL, 1'b1));
      for (int i = 0; i < 2; i++)
      begin
         u_host.send_key(mk(ACT_SEGMENT, i[0] ? FN_BLK_SECTOR : FN_BLK_PATTERN, 16'h0, 16'h0));
         pulse(0);
         waitfor(0, 5, n);
         chk({n > 5, done_o}, 2'b10);
         pulse(i == 0 ? 1 : 2);
         waitfor(0, 6, n);
         chk(n, 2);
         if (i == 1)
            chk(tf_o, img(ES_BLK_FAIL, 1'b1));
         else
         begin
            chk(ext_status_o, ES_DONE);
            chk(tf_o, img(16'h0001, 1'b0));
         end
      end
      conclude();
   end
endmodule // tb
